// ### include/adc_common_pkg.sv
// Constants and carrier types for the converter common control block
// Function
// RQ1: Converter-on bit enables the whole converter; resets to zero.
// RQ2: Software configures fully before enabling and never changes settings while on.
// RQ3: Stop-when-idle set halts the converter during device idle; clear keeps running.
// RQ4: Output format bit selects fractional when set, integer when clear; resets zero.
// RQ5: Two-bit resolution: 11=12, 10=10, 01=8, 00=6 bits; resets to 11.
// RQ6: Reference-ready enable lets band gap ready raise the common interrupt.
// RQ7: Reference-fault enable lets a reference error raise the common interrupt.
// RQ8: Early enable fires channel interrupts on early flag, else on result ready.
// RQ9: Early lead field gives code plus one core periods before data ready.
// RQ10: Divider gives core period of twice code, codes 0 and 1 give two.
// RQ11: At 6-bit resolution software avoids early lead codes 100 to 111.
// RQ12: At 8-bit resolution software avoids early lead codes 110 and 111.
// RQ13: Software writes zero to reserved bits of these registers.
// RQ14: Unimplemented bits read zero and ignore writes.
// RQ15: Reference fault flag sets when band gap vanishes while converter is on.
// RQ16: Common divider forms source clock; core divides it again for core period.
// RQ17: Early request pulses once per conversion when remaining periods reach lead plus one.
package adc_common_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] ADDR_ENABLE_IDLE  = 2'h0;
  localparam logic [1:0] ADDR_FORMAT_RES   = 2'h1;
  localparam logic [1:0] ADDR_IRQ_CLOCK    = 2'h2;
  localparam logic [1:0] ADDR_REF_STATUS   = 2'h3;

  // Field positions
  localparam int BIT_CONVERTER_ON   = 15;
  localparam int BIT_STOP_WHEN_IDLE = 13;
  localparam int BIT_FRACTIONAL     = 7;
  localparam int BIT_RES_LO         = 5;
  localparam int BIT_REF_READY_IE   = 15;
  localparam int BIT_REF_FAULT_IE   = 14;
  localparam int BIT_EARLY_IE       = 12;
  localparam int BIT_LEAD_LO        = 8;
  localparam int BIT_DIV_LO         = 0;
  localparam int BIT_REF_READY      = 15;
  localparam int BIT_REF_FAULT      = 14;

  // Writable masks (implemented bits only)
  localparam logic [15:0] MASK_ENABLE_IDLE = 16'hA000;
  localparam logic [15:0] MASK_FORMAT_RES  = 16'h00E0;
  localparam logic [15:0] MASK_IRQ_CLOCK   = 16'hD77F;

  // Reset values
  localparam logic [1:0] RST_RESOLUTION = 2'h3;
  localparam logic [2:0] RST_LEAD       = 3'h0;
  localparam logic [6:0] RST_DIVIDER    = 7'h00;

  // Resolution codes and minimum core period in source periods
  typedef enum logic [1:0] {
    RES6  = 2'b00,
    RES8  = 2'b01,
    RES10 = 2'b10,
    RES12 = 2'b11
  } resolution_t;

  localparam logic [7:0] MIN_CORE_DIV = 8'h02;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_state_t;

  // Register port bundle
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Channel interrupt outputs
  typedef struct packed {
    logic earlyFlag;
    logic resultReady;
    logic channelIrq;
  } chan_evt_t;

  // Whole block state
  typedef struct packed {
    logic        converterOn;
    logic        stopWhenIdle;
    logic        fractional;
    logic [1:0]  resolution;
    logic        refReadyIe;
    logic        refFaultIe;
    logic        earlyIe;
    logic [2:0]  lead;
    logic [6:0]  divider;
    logic        refReadyFlag;
    logic        refFaultFlag;
    logic        refReadySeen;
    logic [15:0] rdata;
    logic [7:0]  srcCnt;
    logic        coreTick;
    conv_state_t state;
    logic [4:0]  remain;
    logic        earlyDone;
    chan_evt_t   evt;
    logic        commonIrq;
  } state_t;

endpackage

// ### hw/adc_common_control_regs.sv
// Common control registers, core clock divider and early interrupt logic
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module adc_common_control_regs (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clkEn,
  input  wire adc_common_pkg::reg_req_t regReq,
  output logic [15:0]                   regRdata,
  input  wire logic                     deviceIdle,
  input  wire logic                     srcClkTick,
  input  wire logic                     bandGapPin,
  input  wire logic                     convStart,
  output logic                          converterRun,
  output logic                          fractionalOut,
  output logic [1:0]                    resolutionOut,
  output logic                          coreClkTick,
  output logic                          convBusy,
  output adc_common_pkg::chan_evt_t     chanEvt,
  output logic                          commonIrq
);

  // Pin synchronisers for the band gap status
  logic bgMeta_q;
  logic bgSync_q;
  logic bgPrev_q;

  adc_common_pkg::state_t s_q;
  adc_common_pkg::state_t s_d;

  // Conversion length in core periods for a resolution code
  function automatic logic [4:0] convLength(input logic [1:0] res);
    case (res)
      2'b00:   convLength = 5'h06;
      2'b01:   convLength = 5'h08;
      2'b10:   convLength = 5'h0A;
      default: convLength = 5'h0C;
    endcase
  endfunction

  // Core period in source periods for a divider code
  function automatic logic [7:0] corePeriod(input logic [6:0] code);
    logic [7:0] twice;
    twice = {code, 1'b0};
    if (twice < adc_common_pkg::MIN_CORE_DIV)
      corePeriod = adc_common_pkg::MIN_CORE_DIV;
    else
      corePeriod = twice;
  endfunction

  // Two-flop sync of the asynchronous band gap status
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bgMeta_q <= 1'b0;
      bgSync_q <= 1'b0;
      bgPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      bgMeta_q <= bandGapPin;
      bgSync_q <= bgMeta_q;
      bgPrev_q <= bgSync_q;
    end
  end

  logic running;
  logic bgRise;
  logic bgFall;
  assign running = s_q.converterOn && !(s_q.stopWhenIdle && deviceIdle); // RQ1 RQ3
  assign bgRise  = bgSync_q && !bgPrev_q;
  assign bgFall  = !bgSync_q && bgPrev_q;

  // Next-state logic for registers, divider and conversion sequencer
  always_comb
  begin
    s_d = s_q;
    s_d.coreTick = 1'b0;
    s_d.evt = '0;
    s_d.commonIrq = 1'b0;
    s_d.rdata = 16'h0000; // RQ14

    // Register writes, masked to implemented bits
    if (regReq.wr)
    begin
      case (regReq.addr)
        adc_common_pkg::ADDR_ENABLE_IDLE:
        begin
          s_d.converterOn = regReq.wdata[adc_common_pkg::BIT_CONVERTER_ON]; // RQ1
          s_d.stopWhenIdle =
            regReq.wdata[adc_common_pkg::BIT_STOP_WHEN_IDLE]; // RQ3
        end
        adc_common_pkg::ADDR_FORMAT_RES:
        begin
          s_d.fractional = regReq.wdata[adc_common_pkg::BIT_FRACTIONAL]; // RQ4
          s_d.resolution =
            regReq.wdata[adc_common_pkg::BIT_RES_LO +: 2]; // RQ5
        end
        adc_common_pkg::ADDR_IRQ_CLOCK:
        begin
          s_d.refReadyIe = regReq.wdata[adc_common_pkg::BIT_REF_READY_IE];
          s_d.refFaultIe = regReq.wdata[adc_common_pkg::BIT_REF_FAULT_IE];
          s_d.earlyIe = regReq.wdata[adc_common_pkg::BIT_EARLY_IE];
          s_d.lead = regReq.wdata[adc_common_pkg::BIT_LEAD_LO +: 3];
          s_d.divider = regReq.wdata[adc_common_pkg::BIT_DIV_LO +: 7];
        end
        default:
        begin
          // Fault flag clears on write of one, set below wins
          if (regReq.wdata[adc_common_pkg::BIT_REF_FAULT])
            s_d.refFaultFlag = 1'b0;
        end
      endcase
    end

    // Register reads, unimplemented bits return zero
    if (regReq.rd)
    begin
      case (regReq.addr)
        adc_common_pkg::ADDR_ENABLE_IDLE:
        begin
          s_d.rdata[adc_common_pkg::BIT_CONVERTER_ON] = s_q.converterOn;
          s_d.rdata[adc_common_pkg::BIT_STOP_WHEN_IDLE] = s_q.stopWhenIdle;
        end
        adc_common_pkg::ADDR_FORMAT_RES:
        begin
          s_d.rdata[adc_common_pkg::BIT_FRACTIONAL] = s_q.fractional;
          s_d.rdata[adc_common_pkg::BIT_RES_LO +: 2] = s_q.resolution;
        end
        adc_common_pkg::ADDR_IRQ_CLOCK:
        begin
          s_d.rdata[adc_common_pkg::BIT_REF_READY_IE] = s_q.refReadyIe;
          s_d.rdata[adc_common_pkg::BIT_REF_FAULT_IE] = s_q.refFaultIe;
          s_d.rdata[adc_common_pkg::BIT_EARLY_IE] = s_q.earlyIe;
          s_d.rdata[adc_common_pkg::BIT_LEAD_LO +: 3] = s_q.lead;
          s_d.rdata[adc_common_pkg::BIT_DIV_LO +: 7] = s_q.divider;
        end
        default:
        begin
          s_d.rdata[adc_common_pkg::BIT_REF_READY] = s_q.refReadyFlag;
          s_d.rdata[adc_common_pkg::BIT_REF_FAULT] = s_q.refFaultFlag;
        end
      endcase
    end

    // Reference status and common interrupt
    s_d.refReadyFlag = bgSync_q;
    if (bgRise && !s_q.refReadySeen)
    begin
      s_d.refReadySeen = 1'b1;
      s_d.commonIrq = s_q.refReadyIe; // RQ6
    end
    if (bgFall && s_q.converterOn)
    begin
      s_d.refFaultFlag = 1'b1; // RQ15
      s_d.commonIrq = s_q.refFaultIe; // RQ7
    end

    // Core period divider on the source clock ticks
    if (running && srcClkTick) // RQ16
    begin
      if (s_q.srcCnt + 8'h01 >= corePeriod(s_q.divider)) // RQ10
      begin
        s_d.srcCnt = 8'h00;
        s_d.coreTick = 1'b1;
      end
      else
        s_d.srcCnt = s_q.srcCnt + 8'h01;
    end
    if (!running)
      s_d.srcCnt = 8'h00;

    // Shared-core conversion sequencer with early request
    case (s_q.state)
      adc_common_pkg::ST_IDLE:
      begin
        if (running && convStart)
        begin
          s_d.state = adc_common_pkg::ST_CONV;
          s_d.remain = convLength(s_q.resolution); // RQ5
          s_d.earlyDone = 1'b0;
        end
      end
      adc_common_pkg::ST_CONV:
      begin
        if (!running)
          s_d.state = adc_common_pkg::ST_IDLE;
        else if (s_q.coreTick)
        begin
          s_d.remain = s_q.remain - 5'h01;
          if (s_q.remain == 5'h01)
            s_d.state = adc_common_pkg::ST_DONE;
        end
        // Early flag once when remaining periods equal lead plus one
        if (!s_q.earlyDone && running &&
            s_q.remain == {2'b00, s_q.lead} + 5'h01) // RQ9 RQ17
        begin
          s_d.earlyDone = 1'b1;
          s_d.evt.earlyFlag = 1'b1;
          s_d.evt.channelIrq = s_q.earlyIe; // RQ8
        end
      end
      adc_common_pkg::ST_DONE:
      begin
        s_d.state = adc_common_pkg::ST_IDLE;
        s_d.evt.resultReady = 1'b1;
        s_d.evt.channelIrq = !s_q.earlyIe; // RQ8
      end
      default:
        s_d.state = adc_common_pkg::ST_IDLE;
    endcase
  end

  // State register with defaults at reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.resolution <= adc_common_pkg::RST_RESOLUTION; // RQ5
      s_q.lead <= adc_common_pkg::RST_LEAD;
      s_q.divider <= adc_common_pkg::RST_DIVIDER;
      s_q.state <= adc_common_pkg::ST_IDLE;
    end
    else if (clkEn)
      s_q <= s_d;
  end

  assign regRdata      = s_q.rdata;
  assign converterRun  = running;
  assign fractionalOut = s_q.fractional; // RQ4
  assign resolutionOut = s_q.resolution;
  assign coreClkTick   = s_q.coreTick;
  assign convBusy      = (s_q.state == adc_common_pkg::ST_CONV);
  assign chanEvt       = s_q.evt;
  assign commonIrq     = s_q.commonIrq;

  // Converter stays off after reset until enabled
  a_off_after_reset: assert property (@(posedge sys_clk) // RQ1
    $past(sys_rst) |-> !converterRun)
    else $error("converter running right after reset");

  // Idle stop halts the converter
  a_idle_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.stopWhenIdle && deviceIdle |-> !converterRun) // RQ3
    else $error("converter runs in idle with stop set");

  // Format output follows a written value
  a_format_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && regReq.wr && regReq.addr == adc_common_pkg::ADDR_FORMAT_RES
    |=> fractionalOut == $past(regReq.wdata[7])) // RQ4
    else $error("format bit not taken from write");

  // Unimplemented bits read zero
  a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (regRdata & ~(adc_common_pkg::MASK_IRQ_CLOCK |
     adc_common_pkg::MASK_ENABLE_IDLE | adc_common_pkg::MASK_FORMAT_RES))
     == 16'h0000) // RQ14
    else $error("unimplemented bit read nonzero");

  // Minimum core period is two source ticks
  a_core_min: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && coreClkTick |=> !coreClkTick) // RQ10
    else $error("core period shorter than two");

  // Fault flag sets on band gap loss while on
  a_fault_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && bgFall && s_q.converterOn |=> s_q.refFaultFlag) // RQ15
    else $error("fault flag missed");

  // Fault interrupt gated by its enable
  a_fault_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && bgFall && s_q.converterOn && s_q.refFaultIe |=> commonIrq) // RQ7
    else $error("fault interrupt missing");

  // Ready interrupt never fires with its enable clear and no fault
  a_ready_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && bgRise && !s_q.refReadySeen && !bgFall |=>
    commonIrq == $past(s_q.refReadyIe)) // RQ6
    else $error("ready interrupt mismatch");

  // Channel interrupt source chosen by early enable
  a_chan_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
    chanEvt.channelIrq |-> (s_q.earlyIe ? chanEvt.earlyFlag
                                        : chanEvt.resultReady)) // RQ8
    else $error("channel interrupt from wrong source");

  // Early flag pulses a single cycle
  a_early_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && chanEvt.earlyFlag |=> !chanEvt.earlyFlag) // RQ9 RQ17
    else $error("early flag longer than one cycle");

endmodule

// ### testbench/tb_adc_common_control_regs.sv
// Self-checking bench for the converter common control block
`timescale 1ns/1ps
module tb_adc_common_control_regs;
  logic                      sys_clk;
  logic                      sys_rst;
  logic                      clkEn;
  adc_common_pkg::reg_req_t  regReq;
  logic [15:0]               regRdata;
  logic                      deviceIdle;
  logic                      srcClkTick;
  logic                      bandGapPin;
  logic                      convStart;
  logic                      converterRun;
  logic                      fractionalOut;
  logic [1:0]                resolutionOut;
  logic                      coreClkTick;
  logic                      convBusy;
  adc_common_pkg::chan_evt_t chanEvt;
  logic                      commonIrq;
  int                        mismatches;
  int                        comparisons;
  int                        cycles;
  logic [15:0]               rv;
  int                        k;

  adc_common_control_regs u_dut (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .clkEn         (clkEn),
    .regReq        (regReq),
    .regRdata      (regRdata),
    .deviceIdle    (deviceIdle),
    .srcClkTick    (srcClkTick),
    .bandGapPin    (bandGapPin),
    .convStart     (convStart),
    .converterRun  (converterRun),
    .fractionalOut (fractionalOut),
    .resolutionOut (resolutionOut),
    .coreClkTick   (coreClkTick),
    .convBusy      (convBusy),
    .chanEvt       (chanEvt),
    .commonIrq     (commonIrq)
  );

  // Clock, 25 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regReq.addr  <= a;
    regReq.wdata <= d;
    regReq.wr    <= 1'b1;
    @(posedge sys_clk);
    regReq.wr    <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regReq.addr <= a;
    regReq.rd   <= 1'b1;
    @(posedge sys_clk);
    regReq.rd   <= 1'b0;
    #1;
    check("regRdata", regRdata, exp);
  endtask

  // Counts common interrupt pulses over n cycles
  task automatic irqs(input int n);
    k = 0;
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      k += commonIrq;
    end
  endtask

  task automatic t_regs();
    check("resolutionOut", {14'h0000, resolutionOut}, 16'h0003);
    check("converterRun", {15'h0000, converterRun}, 16'h0000);
    rd(2'h0, 16'h0000);
    rd(2'h1, 16'h0060);
    rd(2'h2, 16'h0000);
    wr(2'h1, 16'h00E0);
    wr(2'h2, 16'hD7FF);
    wr(2'h0, 16'hFF87);
    rd(2'h0, 16'hA000);
    rd(2'h1, 16'h00E0);
    rd(2'h2, 16'hD77F);
    check("fractionalOut", {15'h0000, fractionalOut}, 16'h0001);
    wr(2'h0, 16'h0000);
    wr(2'h2, 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      wr(2'h1, 16'(c << 5));
      #1;
      check("resolutionOut", {14'h0000, resolutionOut}, 16'(c));
      check("fractionalOut", {15'h0000, fractionalOut}, 16'h0000);
    end
    // Clock enable low freezes the registers
    clkEn <= 1'b0;
    wr(2'h1, 16'h0080);
    #1;
    check("frozenFormat", {15'h0000, fractionalOut}, 16'h0000);
    check("frozenRes", {14'h0000, resolutionOut}, 16'h0003);
    clkEn <= 1'b1;
  endtask

  // Enable and stop-when-idle gating
  task automatic t_run();
    wr(2'h0, 16'h8000);
    deviceIdle <= 1'b1;
    #1;
    check("converterRun", {15'h0000, converterRun}, 16'h0001);
    wr(2'h0, 16'hA000);
    #1;
    check("converterRun", {15'h0000, converterRun}, 16'h0000);
    @(posedge sys_clk) convStart <= 1'b1;
    @(posedge sys_clk) convStart <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("convBusy", {15'h0000, convBusy}, 16'h0000);
    deviceIdle <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("converterRun", {15'h0000, converterRun}, 16'h0001);
    wr(2'h0, 16'h0000);
    #1;
    check("converterRun", {15'h0000, converterRun}, 16'h0000);
  endtask

  // One shared-core conversion with early lead and divider settings
  task automatic conv(input logic [1:0] res, input logic [2:0] lead,
                      input logic eie, input logic [6:0] div);
    int ne = 0;
    int nr = 0;
    int nt = 0;
    int last = -1;
    int per = -1;
    wr(2'h0, 16'h0000);
    wr(2'h1, {9'h000, res, 5'h00});
    wr(2'h2, {3'h0, eie, 1'h0, lead, 1'h0, div});
    wr(2'h0, 16'h8000);
    @(posedge sys_clk) convStart <= 1'b1;
    @(posedge sys_clk) convStart <= 1'b0;
    for (int i = 0; i < 3000 && nr == 0; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (i == 0)
        check("convBusy", {15'h0000, convBusy}, 16'h0001);
      if (coreClkTick && ne > 0)
        nt++;
      if (coreClkTick && last >= 0 && per < 0)
        per = i - last;
      if (coreClkTick)
        last = i;
      if (chanEvt.earlyFlag)
      begin
        ne++;
        check("irqOnEarly", {15'h0000, chanEvt.channelIrq}, 16'(eie));
      end
      if (chanEvt.resultReady)
      begin
        nr++;
        check("irqOnReady", {15'h0000, chanEvt.channelIrq}, 16'(!eie));
      end
    end
    check("earlyCount", 16'(ne), 16'h0001);
    check("readyCount", 16'(nr), 16'h0001);
    check("corePeriod", 16'(per), (div < 2) ? 16'h0002 : 16'(2 * div));
    if (div > 1)
      check("earlyLead", 16'(nt), 16'(lead + 1));
    wr(2'h0, 16'h0000);
  endtask

  // Band gap ready and fault events
  task automatic t_ref();
    wr(2'h2, 16'hC000);
    wr(2'h0, 16'h8000);
    bandGapPin <= 1'b1;
    irqs(8);
    check("readyIrq", 16'(k), 16'h0001);
    rd(2'h3, 16'h8000);
    bandGapPin <= 1'b0;
    irqs(8);
    check("faultIrq", 16'(k), 16'h0001);
    rd(2'h3, 16'h4000);
    wr(2'h3, 16'h4000);
    rd(2'h3, 16'h0000);
    wr(2'h0, 16'h0000);
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h8000);
    bandGapPin <= 1'b1;
    irqs(8);
    bandGapPin <= 1'b0;
    irqs(8);
    check("maskedFault", 16'(k), 16'h0000);
    rd(2'h3, 16'h4000);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    regReq = '0;
    clkEn = 1'b1;
    deviceIdle = 1'b0;
    srcClkTick = 1'b1;
    bandGapPin = 1'b0;
    convStart = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_regs();
    t_run();
    conv(2'h3, 3'h0, 1'b1, 7'h02);
    conv(2'h3, 3'h7, 1'b0, 7'h05);
    conv(2'h1, 3'h5, 1'b1, 7'h03);
    conv(2'h0, 3'h3, 1'b0, 7'h00);
    conv(2'h2, 3'h4, 1'b1, 7'h01);
    t_ref();
    end_of_test();
  end
endmodule
